/* File: aod_pkg.sv */
/*
 * Constants for the analog output diagnostic record: byte positions,
 * field positions, fixed descriptor values and timer figures.
 * Assumes a single 100 MHz core clock and a synchronous power-on reset.
 */
// Function
// - Summary bit0 failure, bit1 internal error
// - Summary bit2 external, bit3 any channel
// - Summary bit4 aux supply missing
// - Summary bit7 erroneous parameters
// - Module class 0101b in info byte
// - Info bit4 marks channel data present
// - Extended bit3 diagnostics buffer overflow
// - Extended bit4 internal communication error
// - Channel kind code 73h, analog out
// - Diagnostic bits per channel reads 08h
// - Channel count reads 02h
// - Group bits 0/1 for groups 0/1
// - Channel bit0 configuration/parameter error
// - Channel bit3 short to ground
// - Timestamp holds counter at event
// - Microsecond counter starts zero, ticks 1us
// - Counter wraps to zero after maximum
// - Error lights channel indicator, no interrupt
// - Short reported only when enabled
package aod_pkg;
    // Record byte positions
    localparam logic [4:0] AOD_IDX_SUMMARY = 5'h00;
    localparam logic [4:0] AOD_IDX_MODINFO = 5'h01;
    localparam logic [4:0] AOD_IDX_EXT = 5'h03;
    localparam logic [4:0] AOD_IDX_CHKIND = 5'h04;
    localparam logic [4:0] AOD_IDX_DIAG_BITS_PER_CHANNEL = 5'h05;
    localparam logic [4:0] AOD_IDX_CHANNEL_COUNT = 5'h06;
    localparam logic [4:0] AOD_IDX_GRPERR = 5'h07;
    localparam logic [4:0] AOD_IDX_PER_CHANNEL_ERROR_0 = 5'h08;
    localparam logic [4:0] AOD_IDX_PER_CHANNEL_ERROR_1 = 5'h09;
    localparam logic [4:0] AOD_IDX_TS0 = 5'h10;
    localparam logic [4:0] AOD_IDX_TS3 = 5'h13;
    // Summary byte fields
    localparam int AOD_SUM_FAIL = 0;
    localparam int AOD_SUM_INT = 1;
    localparam int AOD_SUM_EXT = 2;
    localparam int AOD_SUM_CHAN = 3;
    localparam int AOD_SUM_AUX = 4;
    localparam int AOD_SUM_PARAM = 7;
    // Extended byte fields
    localparam int AOD_EXT_OVF = 3;
    localparam int AOD_EXT_COMM = 4;
    // Per-channel fields
    localparam int AOD_CH_CFG = 0;
    localparam int AOD_CH_SHORT = 3;
    // Fixed descriptors
    localparam logic [3:0] AOD_CLASS_ANALOG = 4'h5;
    localparam int AOD_MOD_CHINFO = 4;
    localparam logic [6:0] AOD_KIND_ANALOG_OUT = 7'h73;
    localparam logic [7:0] AOD_DIAG_BITS_PER_CHANNEL_VAL = 8'h08;
    localparam logic [7:0] AOD_CHANNEL_COUNT_VAL = 8'h02;
    // Reset values
    localparam logic [7:0] AOD_BYTE_RST = 8'h00;
    localparam logic [31:0] AOD_TS_RST = 32'h0000_0000;
    // Timer figures
    localparam int AOD_CLK_MHZ = 100;
    localparam int AOD_TICK_US = 1;
    localparam int AOD_TICK_CYC = AOD_CLK_MHZ * AOD_TICK_US;
    localparam logic [6:0] AOD_PRESC_MAX = 7'(AOD_TICK_CYC - 1);
endpackage : aod_pkg

/* File: aod_diag_record.sv */
/*
 * Diagnostic record of a two-channel analog output module: error
 * flags, descriptors, channel errors and an event timestamp, read
 * byte by byte from the backplane side.
 * Assumes error sources are asynchronous levels (synchronised here)
 * and the short-circuit enables come from the parameter store.
 */
`timescale 1ns/10ps
module aod_diag_record #(
    parameter int NCH = 2 // Channels
) (
    input wire logic core_clk, // 100 MHz clock
    input wire logic sys_rst, // Sync reset, high
    input wire logic module_fail, // Module failed
    input wire logic internal_err, // Internal error
    input wire logic external_err, // External error
    input wire logic aux_missing, // Aux supply missing
    input wire logic param_err, // Bad parameter set
    input wire logic diag_buf_ovf, // Diag buffer overflow
    input wire logic comm_err, // Internal comm error
    input wire logic [NCH-1:0] ch_cfg_err, // Channel config error
    input wire logic [NCH-1:0] ch_short, // Short to ground seen
    input wire logic [NCH-1:0] short_en, // Short detect enable
    input wire logic rd_en, // Record byte read
    input wire logic [4:0] rd_index, // Record byte index
    output logic [7:0] rd_data, // Read byte
    output logic rd_valid, // Read data valid
    output logic [NCH-1:0] ch_err_led // Channel error lamp
);
    localparam int NIN = 7 + 3 * NCH;

    logic [NIN-1:0] async_in;
    logic [NIN-1:0] sync1_reg;
    logic [NIN-1:0] sync2_reg;
    logic [7:0] summary_reg;
    logic [7:0] summary_next;
    logic [7:0] ext_reg;
    logic [7:0] ext_next;
    logic [7:0] ch_reg [NCH];
    logic [7:0] ch_next [NCH];
    logic [NCH-1:0] grp_next;
    logic [NCH-1:0] grp_reg;
    logic [6:0] presc_reg;
    logic [31:0] us_cnt_reg;
    logic [31:0] ts_reg;
    logic [7:0] rd_data_next;
    logic [NCH-1:0] s_cfg;
    logic [NCH-1:0] s_short;
    logic [NCH-1:0] s_en;
    logic tick;
    logic any_ch;
    logic new_event;
    logic [7:0] mod_info;
    logic [7:0] ch_kind;
    logic [7:0] grp_byte;
    logic [7:0] ts_byte;
    logic [1:0] ts_sel;

    assign async_in = {short_en, ch_short, ch_cfg_err, comm_err, diag_buf_ovf,
                       param_err, aux_missing, external_err, internal_err, module_fail};

    // Two stages before any logic reads the sources
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= async_in;
            sync2_reg <= sync1_reg;
        end
    end

    assign s_cfg = sync2_reg[7 +: NCH];
    assign s_short = sync2_reg[7 + NCH +: NCH];
    assign s_en = sync2_reg[7 + 2 * NCH +: NCH];

    // Per-channel bytes and their group bits
    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_ch
            always_comb begin
                ch_next[g] = aod_pkg::AOD_BYTE_RST;
                ch_next[g][aod_pkg::AOD_CH_CFG] = s_cfg[g];
                ch_next[g][aod_pkg::AOD_CH_SHORT] = s_short[g] & s_en[g];
            end
            assign grp_next[g] = |ch_next[g];
        end
    endgenerate

    assign any_ch = |grp_next;

    always_comb begin
        summary_next = aod_pkg::AOD_BYTE_RST;
        summary_next[aod_pkg::AOD_SUM_FAIL] = sync2_reg[0];
        summary_next[aod_pkg::AOD_SUM_INT] = sync2_reg[1];
        summary_next[aod_pkg::AOD_SUM_EXT] = sync2_reg[2];
        summary_next[aod_pkg::AOD_SUM_CHAN] = any_ch;
        summary_next[aod_pkg::AOD_SUM_AUX] = sync2_reg[3];
        summary_next[aod_pkg::AOD_SUM_PARAM] = sync2_reg[4];
        ext_next = aod_pkg::AOD_BYTE_RST;
        ext_next[aod_pkg::AOD_EXT_OVF] = sync2_reg[5];
        ext_next[aod_pkg::AOD_EXT_COMM] = sync2_reg[6];
    end

    // Event: any summary, extended or group bit rising; a held flag does not retake the stamp
    assign new_event = (|(summary_next & ~summary_reg)) | (|(ext_next & ~ext_reg))
                       | (|(grp_next & ~grp_reg));

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            summary_reg <= aod_pkg::AOD_BYTE_RST;
            ext_reg <= aod_pkg::AOD_BYTE_RST;
            grp_reg <= '0;
        end else begin
            summary_reg <= summary_next;
            ext_reg <= ext_next;
            grp_reg <= grp_next;
        end
    end

    generate
        for (g = 0; g < NCH; g++) begin : g_chreg
            always_ff @(posedge core_clk) begin
                if (sys_rst) begin
                    ch_reg[g] <= aod_pkg::AOD_BYTE_RST;
                end else begin
                    ch_reg[g] <= ch_next[g];
                end
            end
        end
    endgenerate

    // lamp per channel, no interrupt path
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ch_err_led <= '0;
        end else begin
            ch_err_led <= grp_next;
        end
    end

    assign tick = (presc_reg == aod_pkg::AOD_PRESC_MAX);

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            presc_reg <= '0;
        end else if (tick) begin
            presc_reg <= '0;
        end else begin
            presc_reg <= presc_reg + 7'h01;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            us_cnt_reg <= aod_pkg::AOD_TS_RST;
        end else if (tick) begin
            us_cnt_reg <= us_cnt_reg + 32'h0000_0001;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ts_reg <= aod_pkg::AOD_TS_RST;
        end else if (new_event) begin
            ts_reg <= us_cnt_reg;
        end
    end

    assign mod_info = {3'h0, 1'b1, aod_pkg::AOD_CLASS_ANALOG};
    assign ch_kind = {1'b0, aod_pkg::AOD_KIND_ANALOG_OUT};
    assign grp_byte = 8'(grp_reg);
    assign ts_sel = rd_index[1:0];
    // Little-endian timestamp bytes
    assign ts_byte = ts_reg[8 * ts_sel +: 8];

    always_comb begin
        if (rd_index == aod_pkg::AOD_IDX_SUMMARY) begin
            rd_data_next = summary_reg;
        end else if (rd_index == aod_pkg::AOD_IDX_MODINFO) begin
            rd_data_next = mod_info;
        end else if (rd_index == aod_pkg::AOD_IDX_EXT) begin
            rd_data_next = ext_reg;
        end else if (rd_index == aod_pkg::AOD_IDX_CHKIND) begin
            rd_data_next = ch_kind;
        end else if (rd_index == aod_pkg::AOD_IDX_DIAG_BITS_PER_CHANNEL) begin
            rd_data_next = aod_pkg::AOD_DIAG_BITS_PER_CHANNEL_VAL;
        end else if (rd_index == aod_pkg::AOD_IDX_CHANNEL_COUNT) begin
            rd_data_next = aod_pkg::AOD_CHANNEL_COUNT_VAL;
        end else if (rd_index == aod_pkg::AOD_IDX_GRPERR) begin
            rd_data_next = grp_byte;
        end else if (rd_index == aod_pkg::AOD_IDX_PER_CHANNEL_ERROR_0) begin
            rd_data_next = ch_reg[0];
        end else if (rd_index == aod_pkg::AOD_IDX_PER_CHANNEL_ERROR_1 && NCH > 1) begin
            rd_data_next = ch_reg[NCH-1];
        end else if (rd_index >= aod_pkg::AOD_IDX_TS0 && rd_index <= aod_pkg::AOD_IDX_TS3) begin
            rd_data_next = ts_byte;
        end else begin
            // reserved and unused bytes read zero
            rd_data_next = aod_pkg::AOD_BYTE_RST;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rd_data <= aod_pkg::AOD_BYTE_RST;
            rd_valid <= 1'b0;
        end else begin
            rd_data <= rd_en ? rd_data_next : aod_pkg::AOD_BYTE_RST;
            rd_valid <= rd_en;
        end
    end
endmodule // aod_diag_record

/* File: aod_diag_monitor.sv */
/* Checker for the diagnostic record read port and channel lamps.
   Assumes it is bound to aod_diag_record and sees only its ports. */
`timescale 1ns/10ps
module aod_diag_monitor #(
    parameter int NCH = 2 // Channels
) (
    input wire logic core_clk, // Clock
    input wire logic sys_rst, // Reset
    input wire logic [NCH-1:0] ch_cfg_err, // Config errors
    input wire logic [NCH-1:0] ch_short, // Shorts
    input wire logic [NCH-1:0] short_en, // Short enables
    input wire logic rd_en, // Read request
    input wire logic [4:0] rd_index, // Byte index
    input wire logic [7:0] rd_data, // Read byte
    input wire logic [NCH-1:0] ch_err_led // Lamps
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    chk_info_byte: assert property (rd_en && rd_index == 5'h01 |=> rd_data == 8'h15)
        else $error("module info byte wrong");
    chk_kind_code: assert property (rd_en && rd_index == 5'h04 |-> ##1 rd_data == 8'h73)
        else $error("channel kind byte wrong");
    chk_diag_bits_per_channel_val: assert property (rd_en && rd_index == 5'h05 |=> rd_data == 8'h08)
        else $error("diag bits per channel wrong");
    chk_channel_count_val: assert property (rd_en && rd_index == 5'h06 |=> rd_data == 8'h02)
        else $error("channel count wrong");
    chk_sum_reserved: assert property (rd_en && rd_index == 5'h00 |=> rd_data[6:5] == 2'b00)
        else $error("summary reserved bits set");
    chk_ext_reserved: assert property (rd_en && rd_index == 5'h03 |=>
        {rd_data[7:5], rd_data[2:0]} == 6'h00)
        else $error("extended reserved bits set");
    chk_grp_reserved: assert property (rd_en && rd_index == 5'h07 |=> rd_data[7:2] == 6'h00)
        else $error("group reserved bits set");
    chk_lamp_on: assert property (ch_cfg_err[0] [*4] |-> ch_err_led[0])
        else $error("lamp not lit on config error");
    chk_short_mask: assert property (
        (!ch_cfg_err[1] && !(ch_short[1] && short_en[1])) [*4] |-> !ch_err_led[1])
        else $error("lamp lit without enabled error");
endmodule // aod_diag_monitor
bind aod_diag_record aod_diag_monitor #(.NCH(NCH)) i_mon (.core_clk(core_clk), .sys_rst(sys_rst),
    .ch_cfg_err(ch_cfg_err), .ch_short(ch_short), .short_en(short_en), .rd_en(rd_en),
    .rd_index(rd_index), .rd_data(rd_data), .ch_err_led(ch_err_led));

/* File: aod_host.sv */
/* Backplane reader model: fetches one record byte per call.
   Assumes the one-cycle answer latency of the record's read port. */
`timescale 1ns/10ps
module aod_host (
    input wire logic core_clk, // Clock
    output logic rd_en, // Read request
    output logic [4:0] rd_index, // Byte index
    input wire logic [7:0] rd_data, // Read byte
    input wire logic rd_valid // Read valid
);
    initial begin
        rd_en = 1'b0;
        rd_index = 5'h1f;
    end
    task automatic read_byte(input logic [4:0] idx, output logic [7:0] d, output logic ok);
        @(negedge core_clk);
        rd_en = 1'b1;
        rd_index = idx;
        @(negedge core_clk);
        rd_en = 1'b0;
        // Scrambled when idle, so a stale index never helps
        rd_index = ~idx;
        ok = rd_valid;
        d = rd_data;
    endtask
endmodule // aod_host

/* File: analog_output_diag_record_tb_top.sv */
/* Self-checking bench for the diagnostic record.
   Assumes a 100 MHz clock and a 100-cycle microsecond tick. */
`timescale 1ns/10ps
module analog_output_diag_record_tb_top;
    // Starts low, so no falling edge at time zero shortens reset
    logic core_clk = 1'b0;
    logic sys_rst, rd_en, rd_valid;
    logic [6:0] err_v;
    logic [1:0] cfg, shrt, sen, led, g;
    logic [4:0] rd_index;
    logic [7:0] rd_data, d, e, b0, b1;
    logic [31:0] ts1, ts2;
    logic [5:0] ch_case [4] = '{6'b10_00_00, 6'b00_01_00, 6'b00_01_01, 6'b01_11_10};
    int miscompares = 0;
    int cmp_count = 0;
    aod_diag_record #(.NCH(2)) i_dut (.core_clk(core_clk), .sys_rst(sys_rst),
        .module_fail(err_v[0]), .internal_err(err_v[1]), .external_err(err_v[2]),
        .aux_missing(err_v[3]), .param_err(err_v[4]), .diag_buf_ovf(err_v[5]),
        .comm_err(err_v[6]), .ch_cfg_err(cfg), .ch_short(shrt), .short_en(sen),
        .rd_en(rd_en), .rd_index(rd_index), .rd_data(rd_data), .rd_valid(rd_valid),
        .ch_err_led(led));
    aod_host i_host (.core_clk(core_clk), .rd_en(rd_en), .rd_index(rd_index),
        .rd_data(rd_data), .rd_valid(rd_valid));
    initial begin
        forever #5 core_clk = ~core_clk;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        $display("Compares %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic rd(input logic [4:0] idx, input logic [7:0] exp);
        logic ok;
        i_host.read_byte(idx, d, ok);
        check(32'(ok), 32'h1);
        check(32'(d), 32'(exp));
    endtask
    // Bytes 10h..13h, low byte first
    task automatic rd_ts(output logic [31:0] v);
        logic ok;
        for (int i = 0; i < 4; i++) begin
            i_host.read_byte(5'h10 + 5'(i), v[8*i +: 8], ok);
            check(32'(ok), 32'h1);
        end
    endtask
    initial begin
        sys_rst = 1'b1;
        err_v = '0;
        cfg = '0;
        shrt = '0;
        sen = '0;
        repeat (5) @(negedge core_clk);
        sys_rst = 1'b0;
        for (int i = 0; i < 32; i++) begin
            e = i == 1 ? 8'h15 : i == 4 ? 8'h73 : i == 5 ? 8'h08 : i == 6 ? 8'h02 : 8'h00;
            rd(5'(i), e);
        end
        for (int i = 0; i < 7; i++) begin
            err_v = 7'(1 << i);
            repeat (4) @(negedge core_clk);
            rd(5'h00, {err_v[4], 2'b00, err_v[3], 1'b0, err_v[2:0]});
            rd(5'h03, {3'b000, err_v[6:5], 3'b000});
        end
        err_v = '0;
        for (int k = 0; k < 4; k++) begin
            {cfg, shrt, sen} = ch_case[k];
            repeat (4) @(negedge core_clk);
            b0 = {4'h0, shrt[0] & sen[0], 2'b00, cfg[0]};
            b1 = {4'h0, shrt[1] & sen[1], 2'b00, cfg[1]};
            g = {|b1, |b0};
            rd(5'h08, b0);
            rd(5'h09, b1);
            rd(5'h07, {6'h00, g});
            rd(5'h00, {4'h0, |g, 3'b000});
            check(32'(led), 32'(g));
        end
        cfg = '0;
        shrt = '0;
        sen = '0;
        repeat (4) @(negedge core_clk);
        // Two events exactly 1000 cycles apart
        err_v[0] = 1'b1;
        repeat (4) @(negedge core_clk);
        rd_ts(ts1);
        // Stamp taken at the 175th clock after reset: one tick from zero
        check(ts1, 32'h0000_0001);
        err_v[0] = 1'b0;
        repeat (988) @(negedge core_clk);
        err_v[0] = 1'b1;
        repeat (4) @(negedge core_clk);
        rd_ts(ts2);
        check(ts2 - ts1, 32'h0000000a);
        summarize();
    end
endmodule // analog_output_diag_record_tb_top
